// File: core/pio_param_link.sv
// Purpose: four programmable i/o channels tied to parameter objects
// Assumes: parameter store answers each request with a one-cycle ack
// Notes:   channels are served round robin by one shared engine
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ns
`include "pio_defs.svh"
module pio_param_link (
  // clock and reset
  input  wire logic                     clock_i,
  input  wire logic                     nrst_i,
  // register port
  input  wire logic [`PIO_ADDR_W-1:0]   reg_addr_i,
  input  wire logic [`PIO_DATA_W-1:0]   reg_wdata_i,
  input  wire logic                     reg_wr_i,
  input  wire logic                     reg_rd_i,
  output logic      [`PIO_DATA_W-1:0]   reg_rdata_o,
  // i/o pins
  input  wire logic [`PIO_NCH-1:0]      pin_i,
  output logic      [`PIO_NCH-1:0]      pin_o,
  output logic      [`PIO_NCH-1:0]      pin_oe_o,
  // parameter store
  output logic                          param_req_o,
  output logic                          param_we_o,
  output logic      [15:0]              param_index_o,
  output logic      [15:0]              param_subindex_o,
  output logic      [`PIO_DATA_W-1:0]   param_wdata_o,
  input  wire logic                     param_ack_i,
  input  wire logic [`PIO_DATA_W-1:0]   param_rdata_i
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic                     cfg_hit;
  logic [`PIO_CH_W-1:0]     bus_ch;
  logic [`PIO_SUB_W-1:0]    bus_sub;
  logic                     sub_half;
  logic [`PIO_DATA_W-1:0]   mem_wdata;
  logic [`PIO_DATA_W-1:0]   alt_word;
  logic [`PIO_DATA_W-1:0]   eng_rdata;
  logic [`PIO_MEM_AW-1:0]   eng_raddr;

  logic [`PIO_NCH-1:0]      dir_out;
  logic [15:0]              trig_shadow [0:`PIO_NCH-1];

  logic [`PIO_NCH-1:0]      pin_s1;
  logic [`PIO_NCH-1:0]      pin_s2;
  logic [`PIO_NCH-1:0]      pin_prev;
  logic [`PIO_NCH-1:0]      pend_rise;
  logic [`PIO_NCH-1:0]      pend_fall;
  logic [`PIO_NCH-1:0]      clr_rise;
  logic [`PIO_NCH-1:0]      clr_fall;

  pio_pkg::pio_state_t      state;
  logic [`PIO_CH_W-1:0]     rr;
  logic [`PIO_CH_W-1:0]     cur;
  logic [`PIO_SUB_W-1:0]    fcnt;
  logic [`PIO_SUB_W-1:0]    fprev;

  logic [15:0]              cfg_index;
  logic [15:0]              cfg_sub;
  logic [`PIO_DATA_W-1:0]   cfg_mask;
  logic [15:0]              cfg_trig;
  logic [`PIO_DATA_W-1:0]   cfg_val1;
  logic [`PIO_DATA_W-1:0]   cfg_val2;
  logic [`PIO_DATA_W-1:0]   masked;
  logic                     cmp_hit;
  logic                     use_rise;
  logic                     serve_rr;

  ////////////////////////////////////////////////////////////////////////////
  // register port decode
  // channel group select
  assign bus_ch  = reg_addr_i[`PIO_AD_CH_HI:`PIO_AD_CH_LO];
  assign bus_sub = reg_addr_i[`PIO_AD_SUB_HI:`PIO_AD_SUB_LO];
  assign cfg_hit = !reg_addr_i[`PIO_AD_LOCAL_BIT]
                && (reg_addr_i[1:0] == `PIO_AD_ALIGN)
                && (bus_sub >= `PIO_SUB_INDEX)
                && (bus_sub <= `PIO_SUB_VAL2);

  // index, subindex and trigger select are 16-bit words
  assign sub_half  = (bus_sub == `PIO_SUB_INDEX) || (bus_sub == `PIO_SUB_SUBINDEX)
                  || (bus_sub == `PIO_SUB_TRIG);
  assign mem_wdata = sub_half ? (reg_wdata_i & `PIO_HALF_MASK) : reg_wdata_i;

  always_comb begin
    alt_word = `PIO_CFG_RESET;
    case (reg_addr_i)
      `PIO_ADDR_DIR: begin
        alt_word[`PIO_NCH-1:0] = dir_out;
      end
      // base object index visible in status
      `PIO_ADDR_STAT: begin
        alt_word = {`PIO_OBJ_INDEX_BASE, pend_fall, pend_rise, pin_o, pin_s2};
      end
      default: begin
        alt_word = `PIO_CFG_RESET;
      end
    endcase
  end

  pio_cfg_mem u_cfg_mem (
    .clock_i       (clock_i),
    .nrst_i        (nrst_i),
    .we_i          (reg_wr_i && cfg_hit),
    .waddr_i       ({bus_ch, bus_sub}),
    .wdata_i       (mem_wdata),
    .bus_rd_i      (reg_rd_i),
    .bus_sel_mem_i (cfg_hit),
    .bus_raddr_i   ({bus_ch, bus_sub}),
    .bus_alt_i     (alt_word),
    .bus_rdata_o   (reg_rdata_o),
    .eng_raddr_i   (eng_raddr),
    .eng_rdata_o   (eng_rdata)
  );

  // direction word: bit set makes the channel an output
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dir_out <= '0;
    end else if (reg_wr_i && (reg_addr_i == `PIO_ADDR_DIR)) begin
      dir_out <= reg_wdata_i[`PIO_NCH-1:0];
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_oe_o <= '0;
    end else begin
      pin_oe_o <= dir_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel pin sampling and edge capture
  genvar g;
  generate
    for (g = 0; g < `PIO_NCH; g++) begin : g_ch
      logic rise_en;
      logic fall_en;
      logic rise_ev;
      logic fall_ev;

      assign rise_en = (trig_shadow[g] == `PIO_TRIG_RISE)
                    || (trig_shadow[g] == `PIO_TRIG_BOTH);
      assign fall_en = (trig_shadow[g] == `PIO_TRIG_FALL)
                    || (trig_shadow[g] == `PIO_TRIG_BOTH);
      assign rise_ev = pin_s2[g] && !pin_prev[g] && rise_en && !dir_out[g];
      assign fall_ev = !pin_s2[g] && pin_prev[g] && fall_en && !dir_out[g];

      always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
          trig_shadow[g] <= `PIO_TRIG_NONE;
        end else if (reg_wr_i && cfg_hit && (int'(bus_ch) == g)
                     && (bus_sub == `PIO_SUB_TRIG)) begin
          trig_shadow[g] <= reg_wdata_i[15:0];
        end
      end

      // one pending request per edge, set beats clear
      always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
          pend_rise[g] <= 1'b0;
          pend_fall[g] <= 1'b0;
        end else if (dir_out[g]) begin
          pend_rise[g] <= 1'b0;
          pend_fall[g] <= 1'b0;
        end else begin
          pend_rise[g] <= rise_ev || (pend_rise[g] && !clr_rise[g]);
          pend_fall[g] <= fall_ev || (pend_fall[g] && !clr_fall[g]);
        end
      end
    end
  endgenerate

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_s1   <= '0;
      pin_s2   <= '0;
      pin_prev <= '0;
    end else begin
      pin_s1   <= pin_i;
      pin_s2   <= pin_s1;
      pin_prev <= pin_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // engine helpers
  assign serve_rr  = dir_out[rr] || pend_rise[rr] || pend_fall[rr];
  assign eng_raddr = {cur, fcnt};
  assign use_rise  = pend_rise[cur];

  always_comb begin
    clr_rise = '0;
    clr_fall = '0;
    if ((state == pio_pkg::PIO_ST_EVAL) && !dir_out[cur]) begin
      if (use_rise) begin
        clr_rise[cur] = 1'b1;
      end else begin
        clr_fall[cur] = 1'b1;
      end
    end
  end

  always_comb begin
    case (cfg_trig)
      `PIO_CMP_EQ: cmp_hit = (masked == cfg_val1);
      `PIO_CMP_NE: cmp_hit = (masked != cfg_val1);
      `PIO_CMP_LT: cmp_hit = (masked < cfg_val1);
      `PIO_CMP_GT: cmp_hit = (masked > cfg_val1);
      default:     cmp_hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // engine sequence
  // round robin keeps every output refreshed
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= pio_pkg::PIO_ST_IDLE;
      rr    <= '0;
      cur   <= '0;
      fcnt  <= `PIO_SUB_INDEX;
    end else begin
      case (state)
        pio_pkg::PIO_ST_IDLE: begin
          rr   <= rr + 1'b1;
          cur  <= rr;
          fcnt <= `PIO_SUB_INDEX;
          if (serve_rr) begin
            state <= pio_pkg::PIO_ST_FETCH;
          end
        end
        pio_pkg::PIO_ST_FETCH: begin
          fcnt <= fcnt + 1'b1;
          if (fcnt == `PIO_SUB_LAST) begin
            state <= pio_pkg::PIO_ST_READ;
          end
        end
        pio_pkg::PIO_ST_READ: begin
          if (param_ack_i) begin
            state <= pio_pkg::PIO_ST_EVAL;
          end
        end
        pio_pkg::PIO_ST_EVAL: begin
          if (dir_out[cur]) begin
            state <= pio_pkg::PIO_ST_IDLE;
          end else begin
            state <= pio_pkg::PIO_ST_WRITE;
          end
        end
        pio_pkg::PIO_ST_WRITE: begin
          if (param_ack_i) begin
            state <= pio_pkg::PIO_ST_IDLE;
          end
        end
        default: begin
          state <= pio_pkg::PIO_ST_IDLE;
        end
      endcase
    end
  end

  // settings of the served channel, one word per cycle from memory
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fprev     <= '0;
      cfg_index <= '0;
      cfg_sub   <= '0;
      cfg_mask  <= `PIO_CFG_RESET;
      cfg_trig  <= '0;
      cfg_val1  <= `PIO_CFG_RESET;
      cfg_val2  <= `PIO_CFG_RESET;
    end else if (state == pio_pkg::PIO_ST_FETCH) begin
      fprev <= fcnt;
      case (fprev)
        `PIO_SUB_INDEX:    cfg_index <= eng_rdata[15:0];
        `PIO_SUB_SUBINDEX: cfg_sub   <= eng_rdata[15:0];
        `PIO_SUB_MASK:     cfg_mask  <= eng_rdata;
        `PIO_SUB_TRIG:     cfg_trig  <= eng_rdata[15:0];
        `PIO_SUB_VAL1:     cfg_val1  <= eng_rdata;
        `PIO_SUB_VAL2:     cfg_val2  <= eng_rdata;
        default:           cfg_index <= cfg_index;
      endcase
    end else begin
      fprev <= '0;
    end
  end

  // mask applied to every read value
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      masked <= `PIO_CFG_RESET;
    end else if ((state == pio_pkg::PIO_ST_READ) && param_ack_i) begin
      masked <= param_rdata_i & cfg_mask;
    end
  end

  // parameter store request lines
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      param_req_o      <= 1'b0;
      param_we_o       <= 1'b0;
      param_index_o    <= '0;
      param_subindex_o <= '0;
      param_wdata_o    <= `PIO_CFG_RESET;
    end else begin
      case (state)
        pio_pkg::PIO_ST_FETCH: begin
          if (fcnt == `PIO_SUB_LAST) begin
            param_req_o      <= 1'b1;
            param_we_o       <= 1'b0;
            param_index_o    <= cfg_index;
            param_subindex_o <= cfg_sub;
          end
        end
        pio_pkg::PIO_ST_READ: begin
          param_index_o    <= cfg_index;
          param_subindex_o <= cfg_sub;
          if (param_ack_i) begin
            param_req_o <= 1'b0;
          end
        end
        pio_pkg::PIO_ST_EVAL: begin
          if (!dir_out[cur]) begin
            param_req_o <= 1'b1;
            param_we_o  <= 1'b1;
            param_wdata_o <= masked | (use_rise ? cfg_val1 : cfg_val2);
          end
        end
        pio_pkg::PIO_ST_WRITE: begin
          if (param_ack_i) begin
            param_req_o <= 1'b0;
            param_we_o  <= 1'b0;
          end
        end
        default: begin
          param_req_o <= 1'b0;
          param_we_o  <= 1'b0;
        end
      endcase
    end
  end

  // index and subindex lines follow the fetched settings before the request
  // is seen, because the first request cycle already carries them

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_o <= '0;
    end else begin
      for (int i = 0; i < `PIO_NCH; i++) begin
        if (!dir_out[i]) begin
          pin_o[i] <= 1'b0;
        end else if ((state == pio_pkg::PIO_ST_EVAL)
                     && (cur == i[`PIO_CH_W-1:0])) begin
          pin_o[i] <= cmp_hit;
        end
      end
    end
  end

endmodule : pio_param_link

// File: core/pio_defs.svh
// Purpose: constants for the programmable i/o parameter link
// Assumes: byte addresses on an 8-bit register port, 32-bit data
// Notes:   included by bare name from every design file except the package
`ifndef PIO_DEFS_SVH
`define PIO_DEFS_SVH

// channel count and object placement
`define PIO_NCH             4
`define PIO_CH_W            2
`define PIO_OBJ_INDEX_BASE  16'h0320

// register port geometry
`define PIO_ADDR_W          8
`define PIO_DATA_W          32
`define PIO_MEM_AW          5
`define PIO_SUB_W           3

// subindices of one channel group, also the word slot inside the group
`define PIO_SUB_INDEX       3'h1
`define PIO_SUB_SUBINDEX    3'h2
`define PIO_SUB_MASK        3'h3
`define PIO_SUB_TRIG        3'h4
`define PIO_SUB_VAL1        3'h5
`define PIO_SUB_VAL2        3'h6
`define PIO_SUB_LAST        3'h7

// address fields: [7] selects local words, [6:5] channel, [4:2] subindex
`define PIO_AD_LOCAL_BIT    7
`define PIO_AD_CH_HI        6
`define PIO_AD_CH_LO        5
`define PIO_AD_SUB_HI       4
`define PIO_AD_SUB_LO       2
`define PIO_AD_ALIGN        2'h0

// local words
`define PIO_ADDR_DIR        8'h80
`define PIO_ADDR_STAT       8'h84

// trigger select codes, input use
`define PIO_TRIG_NONE       16'h0000
`define PIO_TRIG_RISE       16'h0001
`define PIO_TRIG_FALL       16'h0002
`define PIO_TRIG_BOTH       16'h0003

// trigger select codes, output use
`define PIO_CMP_EQ          16'h0000
`define PIO_CMP_NE          16'h0001
`define PIO_CMP_LT          16'h0002
`define PIO_CMP_GT          16'h0003

// field widths and reset values
`define PIO_HALF_MASK       32'h0000ffff
`define PIO_CFG_RESET       32'h00000000

`endif

// File: core/pio_pkg.sv
// Purpose: shared types of the programmable i/o parameter link
// Assumes: constants come from pio_defs.svh
// Notes:   one-hot engine states
package pio_pkg;

  typedef enum logic [4:0] {
    PIO_ST_IDLE  = 5'h01,
    PIO_ST_FETCH = 5'h02,
    PIO_ST_READ  = 5'h04,
    PIO_ST_EVAL  = 5'h08,
    PIO_ST_WRITE = 5'h10
  } pio_state_t;

endpackage : pio_pkg

// File: core/pio_cfg_mem.sv
// Purpose: settings memory, one 32-bit word per channel and subindex
// Assumes: one write port, two registered read ports
// Notes:   bus port also returns a local word when the address is not here
`timescale 1ns/1ns
`include "pio_defs.svh"
module pio_cfg_mem (
  // clock and reset
  input  wire logic                     clock_i,
  input  wire logic                     nrst_i,
  // write port
  input  wire logic                     we_i,
  input  wire logic [`PIO_MEM_AW-1:0]   waddr_i,
  input  wire logic [`PIO_DATA_W-1:0]   wdata_i,
  // register port read
  input  wire logic                     bus_rd_i,
  input  wire logic                     bus_sel_mem_i,
  input  wire logic [`PIO_MEM_AW-1:0]   bus_raddr_i,
  input  wire logic [`PIO_DATA_W-1:0]   bus_alt_i,
  output logic      [`PIO_DATA_W-1:0]   bus_rdata_o,
  // engine read
  input  wire logic [`PIO_MEM_AW-1:0]   eng_raddr_i,
  output logic      [`PIO_DATA_W-1:0]   eng_rdata_o
);

  logic [`PIO_DATA_W-1:0] mem [0:(1<<`PIO_MEM_AW)-1];

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < (1<<`PIO_MEM_AW); i++) begin
        mem[i] <= `PIO_CFG_RESET;
      end
    end else if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // read data stand for exactly one cycle after the strobe
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bus_rdata_o <= `PIO_CFG_RESET;
    end else if (bus_rd_i) begin
      bus_rdata_o <= bus_sel_mem_i ? mem[bus_raddr_i] : bus_alt_i;
    end else begin
      bus_rdata_o <= `PIO_CFG_RESET;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      eng_rdata_o <= `PIO_CFG_RESET;
    end else begin
      eng_rdata_o <= mem[eng_raddr_i];
    end
  end

endmodule : pio_cfg_mem

// File: testbench/pio_store_model.sv
// Purpose: behavioural parameter store on the far side of the link
// Assumes: one request at a time, contents keyed by index and subindex
// Notes:   ack after delay_i+2 request cycles; read data scrambled outside ack
`timescale 1ns/1ns
module pio_store_model (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  // request side
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [15:0] index_i,
  input  wire logic [15:0] subindex_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  delay_i,
  // answer side
  output logic             ack_o,
  output logic [31:0]      rdata_o
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] key;
  logic [4:0]  wait_cnt;
  int          num_writes;

  assign key = {index_i, subindex_i};

  ////////////////////////////////////////////////////////////////////////////
  // never acks in the first request cycle, index may still be settling
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_o      <= 1'b0;
      rdata_o    <= 32'h0;
      wait_cnt   <= 5'h00;
      num_writes <= 0;
    end else if (req_i && !ack_o && wait_cnt == {1'b0, delay_i} + 5'h01) begin
      ack_o    <= 1'b1;
      wait_cnt <= 5'h00;
      rdata_o  <= mem.exists(key) ? mem[key] : 32'h0;
      if (we_i) begin
        mem[key] = wdata_i;
        num_writes <= num_writes + 1;
      end
    end else begin
      ack_o   <= 1'b0;
      rdata_o <= ~rdata_o;
      if (req_i && !ack_o) begin
        wait_cnt <= wait_cnt + 5'h01;
      end
    end
  end
endmodule : pio_store_model

// File: testbench/pio_link_assertions.sv
// Purpose: port-level checks of the parameter link
// Assumes: sees only the top module ports
// Notes:   bound into every instance of the top module
`timescale 1ns/1ns
`include "pio_defs.svh"
module pio_link_checker (
  // clock and reset
  input wire logic                   clock_i,
  input wire logic                   nrst_i,
  // register port
  input wire logic [`PIO_ADDR_W-1:0] reg_addr_i,
  input wire logic [`PIO_DATA_W-1:0] reg_wdata_i,
  input wire logic                   reg_wr_i,
  input wire logic                   reg_rd_i,
  input wire logic [`PIO_DATA_W-1:0] reg_rdata_o,
  // pins
  input wire logic [`PIO_NCH-1:0]    pin_i,
  input wire logic [`PIO_NCH-1:0]    pin_o,
  input wire logic [`PIO_NCH-1:0]    pin_oe_o,
  // parameter store
  input wire logic                   param_req_o,
  input wire logic                   param_we_o,
  input wire logic [15:0]            param_index_o,
  input wire logic [15:0]            param_subindex_o,
  input wire logic [`PIO_DATA_W-1:0] param_wdata_o,
  input wire logic                   param_ack_i,
  input wire logic [`PIO_DATA_W-1:0] param_rdata_i
);
  logic [3:0] dir_lo;
  assign dir_lo = reg_wdata_i[3:0];

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);

  ////////////////////////////////////////////////////////////////////////////
  rdata_idle_a:
    assert property (!reg_rd_i |=> reg_rdata_o == '0) else $error("read data not idle");
  status_id_a:
    assert property (reg_rd_i && reg_addr_i == `PIO_ADDR_STAT
      |=> reg_rdata_o[31:16] == `PIO_OBJ_INDEX_BASE) else $error("object base wrong");
  misalign_zero_a:
    assert property (reg_rd_i && reg_addr_i[1:0] != 2'h0 |=> reg_rdata_o == '0)
      else $error("misaligned read not zero");
  sub_gap_a:
    assert property (reg_rd_i && !reg_addr_i[7] && reg_addr_i[4:2] inside {3'h0, 3'h7}
      |=> reg_rdata_o == '0) else $error("unmapped subindex not zero");
  req_hold_a:
    assert property (param_req_o && !param_ack_i
      |=> param_req_o && $stable(param_we_o) && $stable(param_wdata_o)
          && $stable(param_index_o) && $stable(param_subindex_o))
      else $error("request not held");
  ack_drop_a:
    assert property (param_ack_i |=> !param_req_o) else $error("request kept after ack");
  write_after_read_a:
    assert property ($rose(param_req_o) && param_we_o
      |-> $past(param_ack_i, 2) && !$past(param_we_o, 2)) else $error("write without read");
  dir_copy_a:
    assert property (reg_wr_i && reg_addr_i == `PIO_ADDR_DIR
      |-> ##2 pin_oe_o == $past(dir_lo, 2)) else $error("output enable wrong");

  cover property (param_req_o && param_we_o && param_ack_i);
  cover property ($rose(pin_o[0]));
  cover property (reg_rd_i && reg_addr_i == `PIO_ADDR_STAT);
endmodule : pio_link_checker

bind pio_param_link pio_link_checker u_checker (
  .clock_i(clock_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pin_i(pin_i),
  .pin_o(pin_o), .pin_oe_o(pin_oe_o), .param_req_o(param_req_o), .param_we_o(param_we_o),
  .param_index_o(param_index_o), .param_subindex_o(param_subindex_o),
  .param_wdata_o(param_wdata_o), .param_ack_i(param_ack_i), .param_rdata_i(param_rdata_i)
);

// File: testbench/test_pio_param_link.sv
// Purpose: self-checking bench of the parameter link
// Assumes: store model answers with a settable delay
// Notes:   fixed waits of 200 cycles cover one full engine round
`timescale 1ns/1ns
`include "pio_defs.svh"
module test_pio_param_link;
  logic        clock_i, nrst_i, reg_wr_i, reg_rd_i;
  logic [7:0]  reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, param_wdata_o, param_rdata_i;
  logic [3:0]  pin_i, pin_o, pin_oe_o, store_delay;
  logic        param_req_o, param_we_o, param_ack_i;
  logic [15:0] param_index_o, param_subindex_o;
  int          num_errors = 0;
  int          tests_run = 0;

  pio_param_link DUT (
    .clock_i(clock_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe_o(pin_oe_o), .param_req_o(param_req_o), .param_we_o(param_we_o),
    .param_index_o(param_index_o), .param_subindex_o(param_subindex_o),
    .param_wdata_o(param_wdata_o), .param_ack_i(param_ack_i), .param_rdata_i(param_rdata_i));

  pio_store_model STORE (
    .clock_i(clock_i), .nrst_i(nrst_i), .req_i(param_req_o), .we_i(param_we_o),
    .index_i(param_index_o), .subindex_i(param_subindex_o), .wdata_i(param_wdata_o),
    .delay_i(store_delay), .ack_o(param_ack_i), .rdata_o(param_rdata_i));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clock_i);
    reg_wr_i    <= 1'b0;
  endtask : reg_write

  // read data stand only in the cycle after the strobe
  task automatic reg_check(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clock_i);
    reg_rd_i   <= 1'b0;
    #1 chk($sformatf("reg %h", a), reg_rdata_o, exp);
  endtask : reg_check

  task automatic cfg(input int ch, input logic [31:0] w [6]);
    for (int s = 1; s <= 6; s++) reg_write(8'(ch * 32 + s * 4), w[s-1]);
  endtask : cfg

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (20000) @(posedge clock_i);
    num_errors++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] key, exp, m, v;
    logic [31:0] vals [3];
    int          n0;
    vals = '{32'h0000_1240, 32'h0000_0041, 32'h0000_003f};
    nrst_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 32'h0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    pin_i = 4'h0;
    store_delay = 4'h0;
    repeat (2) @(posedge clock_i);
    nrst_i <= 1'b1;
    // register map, unmapped and misaligned places
    reg_check(`PIO_ADDR_STAT, 32'h0320_0000);
    reg_check(8'h00, 32'h0);
    reg_check(8'h1c, 32'h0);
    reg_check(8'h22, 32'h0);
    for (int c = 0; c < 4; c++) begin
      for (int s = 1; s <= 6; s++) begin
        key = 32'(c * 32 + s * 4);
        exp = (32'hc3a5_0000 | key) & ((s == 5 || s == 6 || s == 3) ? 32'hffff_ffff : 32'hffff);
        reg_check(key[7:0], 32'h0);
        reg_write(key[7:0], 32'hc3a5_0000 | key);
        reg_check(key[7:0], exp);
      end
    end
    $display("test register_map done");
    // input edges, trigger code equals channel number
    for (int c = 0; c < 4; c++) begin
      store_delay <= 4'(c * 2);
      cfg(c, '{32'h10 + c, 32'h1, 32'h0000_ff00, c, 32'h11, 32'h22});
      key = {16'(16'h10 + c), 16'h1};
      for (int e = 1; e >= 0; e--) begin
        STORE.mem[key] = 32'h1234_5678;
        n0 = STORE.num_writes;
        @(posedge clock_i);
        pin_i[c] <= e[0];
        repeat (200) @(posedge clock_i);
        exp = (e == 1) ? ((c % 2 == 1) ? 32'h5611 : 32'h1234_5678)
                       : ((c >= 2) ? 32'h5622 : 32'h1234_5678);
        chk("edge value", STORE.mem[key], exp);
        chk("edge writes", 32'(STORE.num_writes - n0), {31'h0, exp != 32'h1234_5678});
      end
    end
    $display("test input_edges done");
    // output comparisons, falling value changed as noise
    store_delay <= 4'h3;
    n0 = STORE.num_writes;
    reg_write(`PIO_ADDR_DIR, 32'h1);
    cfg(0, '{32'h40, 32'h2, 32'h0000_00ff, 32'h0, 32'h40, 32'h0});
    for (int op = 0; op < 4; op++) begin
      for (int i = 0; i < 3; i++) begin
        v = vals[i];
        STORE.mem[{16'h40, 16'h2}] = v;
        reg_write(8'h10, 32'(op));
        reg_write(8'h18, ~v);
        repeat (200) @(posedge clock_i);
        m = v & 32'hff;
        exp = (op == 0) ? 32'(m == 32'h40) : (op == 1) ? 32'(m != 32'h40)
            : (op == 2) ? 32'(m < 32'h40) : 32'(m > 32'h40);
        chk("pin level", {28'h0, pin_o}, exp);
      end
    end
    chk("output enable", {28'h0, pin_oe_o}, 32'h1);
    chk("output writes", 32'(STORE.num_writes - n0), 32'h0);
    $display("test output_compare done");
    print_verdict();
  end
endmodule : test_pio_param_link
